// ---- sdram_timing_pkg.sv ----
// Constants for the SDRAM command timing register block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package sdram_timing_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 32;
  localparam logic [ADDR_W-1:0] SELF_REFRESH_EXIT_TIME_ADDR = 32'h80008038;
  localparam logic [ADDR_W-1:0] LAST_DATA_OUT_TO_ACTIVE_TIME_ADDR = 32'h8000803C;
  localparam logic [ADDR_W-1:0] DATA_IN_TO_ACTIVE_TIME_ADDR = 32'h80008040;
  localparam logic [ADDR_W-1:0] WRITE_RECOVERY_TIME_ADDR = 32'h80008044;
  localparam logic [ADDR_W-1:0] ACTIVE_TO_ACTIVE_PERIOD_ADDR = 32'h80008048;
  // Sequencer pacing status register
  localparam logic [ADDR_W-1:0] PACING_STATUS_ADDR = 32'h8000805C;

  // ****************************************
  // Field widths and reset values
  // ****************************************
  localparam int NARROW_W = 4;
  localparam int WIDE_W = 5;
  localparam logic [NARROW_W-1:0] NARROW_RESET = 4'hF;
  localparam logic [WIDE_W-1:0] WIDE_RESET = 5'h1F;
  localparam int NUM_TIMERS = 5;

  // Timer index per command pair
  localparam int TMR_EXIT = 0;
  localparam int TMR_READ = 1;
  localparam int TMR_WRITE = 2;
  localparam int TMR_RECOVERY = 3;
  localparam int TMR_ACTIVATE = 4;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_e;

endpackage

// ---- interval_timer.sv ----
// One command interval timer: a load starts N+1 cycles of blocking.
// Assumes the interval value is stable while the timer runs.
`timescale 1ns/10ps
module interval_timer #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Control
  input wire logic start_i,
  input wire logic [W-1:0] interval_i,
  // Status
  output logic busy_o
);

  logic [W:0] count_r;
  logic [W:0] count_nxt;

  // Refuse a zero-width interval
  if (W < 1) begin : g_bad_w
    $error("interval_timer: W must be at least 1");
  end

  // Load N+1, count down to zero
  assign count_nxt = start_i ? ({1'b0, interval_i} + {{W{1'b0}}, 1'b1}) :
                     (count_r != '0) ? count_r - {{W{1'b0}}, 1'b1} : count_r;
  assign busy_o = (count_r != '0);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule

// ---- sdram_command_timing_regs.sv ----
// SDRAM command timing registers with the pacing timers that use them.
// Assumes an AXI4-Lite master on the system clock and a sequencer that
// raises event strobes and honours the matching hold-off outputs.
`timescale 1ns/10ps

module sdram_command_timing_regs (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // AXI4-Lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sequencer events
  input wire logic self_refresh_exit_i,
  input wire logic last_data_out_i,
  input wire logic last_data_in_i,
  input wire logic activate_i,
  // Sequencer hold-offs
  output logic hold_activate_o,
  output logic hold_precharge_o
);

  // ****************************************
  // Timing registers
  // ****************************************
  logic [sdram_timing_pkg::NARROW_W-1:0] srex_r;
  logic [sdram_timing_pkg::NARROW_W-1:0] apr_r;
  logic [sdram_timing_pkg::NARROW_W-1:0] dal_r;
  logic [sdram_timing_pkg::NARROW_W-1:0] wr_r;
  logic [sdram_timing_pkg::WIDE_W-1:0] rc_r;

  // ****************************************
  // Write channel
  // ****************************************
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic wr_wait_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_both = (aw_held_r || aw_take) && (w_held_r || w_take) && !wr_wait_r && !bvalid_r;
  wire wr_commit = wr_wait_r;
  wire wr_hit_srex = (awaddr_r == sdram_timing_pkg::SELF_REFRESH_EXIT_TIME_ADDR);
  wire wr_hit_apr = (awaddr_r == sdram_timing_pkg::LAST_DATA_OUT_TO_ACTIVE_TIME_ADDR);
  wire wr_hit_dal = (awaddr_r == sdram_timing_pkg::DATA_IN_TO_ACTIVE_TIME_ADDR);
  wire wr_hit_wr = (awaddr_r == sdram_timing_pkg::WRITE_RECOVERY_TIME_ADDR);
  wire wr_hit_rc = (awaddr_r == sdram_timing_pkg::ACTIVE_TO_ACTIVE_PERIOD_ADDR);
  wire wr_hit_stat = (awaddr_r == sdram_timing_pkg::PACING_STATUS_ADDR);
  wire wr_mapped = wr_hit_srex || wr_hit_apr || wr_hit_dal || wr_hit_wr || wr_hit_rc || wr_hit_stat;
  wire wr_en = wr_commit && wstrb0_r;

  assign s_axi_awready = !aw_held_r && !wr_wait_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !wr_wait_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      aw_held_r <= wr_both ? 1'b0 : (aw_held_r || aw_take);
      w_held_r <= wr_both ? 1'b0 : (w_held_r || w_take);
    end
  end

  // One wait state between taking both halves and the response
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wr_wait_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= sdram_timing_pkg::RESP_OKAY;
    end else begin
      wr_wait_r <= wr_both;
      if (wr_commit) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? sdram_timing_pkg::RESP_OKAY : sdram_timing_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Reserved upper bits are dropped on write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      srex_r <= sdram_timing_pkg::NARROW_RESET;
      apr_r <= sdram_timing_pkg::NARROW_RESET;
      dal_r <= sdram_timing_pkg::NARROW_RESET;
      wr_r <= sdram_timing_pkg::NARROW_RESET;
      rc_r <= sdram_timing_pkg::WIDE_RESET;
    end else if (wr_en) begin
      if (wr_hit_srex) srex_r <= wdata_r[sdram_timing_pkg::NARROW_W-1:0];
      if (wr_hit_apr) apr_r <= wdata_r[sdram_timing_pkg::NARROW_W-1:0];
      if (wr_hit_dal) dal_r <= wdata_r[sdram_timing_pkg::NARROW_W-1:0];
      if (wr_hit_wr) wr_r <= wdata_r[sdram_timing_pkg::NARROW_W-1:0];
      if (wr_hit_rc) rc_r <= wdata_r[sdram_timing_pkg::WIDE_W-1:0];
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  sdram_timing_pkg::bus_state_e rd_state_r;
  sdram_timing_pkg::bus_state_e rd_state_nxt;
  logic [31:0] araddr_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [sdram_timing_pkg::NUM_TIMERS-1:0] busy;
  wire rd_hit_srex = (araddr_r == sdram_timing_pkg::SELF_REFRESH_EXIT_TIME_ADDR);
  wire rd_hit_apr = (araddr_r == sdram_timing_pkg::LAST_DATA_OUT_TO_ACTIVE_TIME_ADDR);
  wire rd_hit_dal = (araddr_r == sdram_timing_pkg::DATA_IN_TO_ACTIVE_TIME_ADDR);
  wire rd_hit_wr = (araddr_r == sdram_timing_pkg::WRITE_RECOVERY_TIME_ADDR);
  wire rd_hit_rc = (araddr_r == sdram_timing_pkg::ACTIVE_TO_ACTIVE_PERIOD_ADDR);
  wire rd_hit_stat = (araddr_r == sdram_timing_pkg::PACING_STATUS_ADDR);
  wire rd_mapped = rd_hit_srex || rd_hit_apr || rd_hit_dal || rd_hit_wr || rd_hit_rc || rd_hit_stat;
  // Reserved bits read as zero
  wire [31:0] rd_mux =
    rd_hit_srex ? {28'h0000000, srex_r} :
    rd_hit_apr ? {28'h0000000, apr_r} :
    rd_hit_dal ? {28'h0000000, dal_r} :
    rd_hit_wr ? {28'h0000000, wr_r} :
    rd_hit_rc ? {27'h0000000, rc_r} :
    rd_hit_stat ? {27'h0000000, busy} : 32'h00000000;

  assign s_axi_arready = (rd_state_r == sdram_timing_pkg::BUS_IDLE);
  assign s_axi_rvalid = (rd_state_r == sdram_timing_pkg::BUS_RESP);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_comb begin
    case (rd_state_r)
      sdram_timing_pkg::BUS_IDLE: begin
        rd_state_nxt = s_axi_arvalid ? sdram_timing_pkg::BUS_WAIT : sdram_timing_pkg::BUS_IDLE;
      end
      sdram_timing_pkg::BUS_WAIT: begin
        rd_state_nxt = sdram_timing_pkg::BUS_RESP;
      end
      sdram_timing_pkg::BUS_RESP: begin
        rd_state_nxt = s_axi_rready ? sdram_timing_pkg::BUS_IDLE : sdram_timing_pkg::BUS_RESP;
      end
      default: begin
        rd_state_nxt = sdram_timing_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rd_state_r <= sdram_timing_pkg::BUS_IDLE;
      araddr_r <= '0;
      rdata_r <= '0;
      rresp_r <= sdram_timing_pkg::RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_r <= s_axi_araddr;
      end
      if (rd_state_r == sdram_timing_pkg::BUS_WAIT) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_mapped ? sdram_timing_pkg::RESP_OKAY : sdram_timing_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Command pacing timers
  // ****************************************
  // Widened copies so one generate loop serves all pairs
  logic [sdram_timing_pkg::WIDE_W-1:0] interval [sdram_timing_pkg::NUM_TIMERS];
  logic [sdram_timing_pkg::NUM_TIMERS-1:0] start;
  // Widening below assumes the wide field is one bit wider
  if (sdram_timing_pkg::WIDE_W != sdram_timing_pkg::NARROW_W + 1) begin : g_bad_width
    $error("sdram_command_timing_regs: wide field must be one bit wider than narrow field");
  end
  assign interval[sdram_timing_pkg::TMR_EXIT] = {1'b0, srex_r};
  assign interval[sdram_timing_pkg::TMR_READ] = {1'b0, apr_r};
  assign interval[sdram_timing_pkg::TMR_WRITE] = {1'b0, dal_r};
  assign interval[sdram_timing_pkg::TMR_RECOVERY] = {1'b0, wr_r};
  assign interval[sdram_timing_pkg::TMR_ACTIVATE] = rc_r;
  assign start[sdram_timing_pkg::TMR_EXIT] = self_refresh_exit_i;
  assign start[sdram_timing_pkg::TMR_READ] = last_data_out_i;
  assign start[sdram_timing_pkg::TMR_WRITE] = last_data_in_i;
  assign start[sdram_timing_pkg::TMR_RECOVERY] = last_data_in_i;
  assign start[sdram_timing_pkg::TMR_ACTIVATE] = activate_i;

  genvar g;
  generate
    for (g = 0; g < sdram_timing_pkg::NUM_TIMERS; g++) begin : g_timer
      interval_timer #(
        .W(sdram_timing_pkg::WIDE_W)
      ) u_timer (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .start_i(start[g]),
        .interval_i(interval[g]),
        .busy_o(busy[g])
      );
    end
  endgenerate

  // Activate waits on exit, read-out, write-in and activate intervals
  assign hold_activate_o = busy[sdram_timing_pkg::TMR_EXIT] || busy[sdram_timing_pkg::TMR_READ] ||
                           busy[sdram_timing_pkg::TMR_WRITE] || busy[sdram_timing_pkg::TMR_ACTIVATE];
  // Precharge waits on write recovery
  assign hold_precharge_o = busy[sdram_timing_pkg::TMR_RECOVERY];

endmodule

// ---- sdram_command_timing_regs_props.sv ----
// Bus and pacing checker for the SDRAM timing register block.
// Assumes binding to the block's top module ports.
`timescale 1ns/10ps
module sdram_timing_props (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic self_refresh_exit_i,
  input wire logic last_data_out_i,
  input wire logic last_data_in_i,
  input wire logic activate_i,
  input wire logic hold_activate_o,
  input wire logic hold_precharge_o
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire any_ev = activate_i || self_refresh_exit_i || last_data_out_i || last_data_in_i;
  sequence b_one_wait;
    ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence r_one_wait;
    ##1 !s_axi_rvalid ##1 s_axi_rvalid;
  endsequence
  wr_wait_a: assert property (wr_take |-> b_one_wait)
    else $error("write answer not after one wait");
  rd_wait_a: assert property (rd_take |-> r_one_wait)
    else $error("read answer not after one wait");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  rsvd_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
    else $error("upper read bits not zero");
  act_hold_a: assert property (any_ev |=> hold_activate_o)
    else $error("activate not held after event");
  pre_hold_a: assert property (last_data_in_i |=> hold_precharge_o)
    else $error("precharge not held after write data");
  pre_idle_a: assert property (!hold_precharge_o && !last_data_in_i |=> !hold_precharge_o)
    else $error("precharge hold without cause");
endmodule

bind sdram_command_timing_regs sdram_timing_props u_props (
  .clk_sys_i, .rst_b_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .self_refresh_exit_i, .last_data_out_i, .last_data_in_i, .activate_i, .hold_activate_o, .hold_precharge_o
);

// ---- sdram_sequencer_model.sv ----
// Command sequencer model: issues one event, measures the hold it causes.
// Assumes go is a one-cycle request with kind held until done.
`timescale 1ns/10ps
module sdram_sequencer_model (
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic [2:0] kind_i,
  input wire logic hold_activate_i,
  input wire logic hold_precharge_i,
  output logic self_refresh_exit_o,
  output logic last_data_out_o,
  output logic last_data_in_o,
  output logic activate_o,
  output logic [6:0] len_o,
  output logic done_o
);
  logic [3:0] ev = 4'h0;
  int n;
  assign {activate_o, last_data_in_o, last_data_out_o, self_refresh_exit_o} = ev;
  initial len_o = 7'h00;
  initial done_o = 1'b0;
  always begin
    @(posedge clk_sys_i iff go_i);
    done_o <= 1'b0;
    #1;
    while (hold_activate_i || hold_precharge_i) begin
      @(posedge clk_sys_i);
      #1;
    end
    @(posedge clk_sys_i);
    ev <= 4'h1 << (kind_i == 3'h4 ? 3 : kind_i == 3'h3 ? 2 : kind_i);
    @(posedge clk_sys_i);
    ev <= 4'h0;
    n = 0;
    #1;
    while (kind_i == 3'h3 ? hold_precharge_i : hold_activate_i) begin
      n++;
      @(posedge clk_sys_i);
      #1;
    end
    len_o <= 7'(n);
    done_o <= 1'b1;
  end
endmodule

// ---- sdram_command_timing_regs_bench.sv ----
// Self-checking bench for the SDRAM timing register block.
// Assumes the checker is bound in its own file.
`timescale 1ns/10ps
module sdram_command_timing_regs_bench;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, fld [5], d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, go = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, done;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic self_refresh_exit_i, last_data_out_i, last_data_in_i, activate_i, hold_activate_o, hold_precharge_o;
  logic [2:0] kind = 3'h0;
  logic [6:0] len;
  int mismatches = 0, n_compared = 0, cyc = 0, seed = 52, lag = 0;
  sdram_command_timing_regs dut (
    .clk_sys_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .self_refresh_exit_i,
    .last_data_out_i, .last_data_in_i, .activate_i, .hold_activate_o, .hold_precharge_o);
  sdram_sequencer_model seq (.clk_sys_i, .go_i(go), .kind_i(kind), .hold_activate_i(hold_activate_o),
    .hold_precharge_i(hold_precharge_o), .self_refresh_exit_o(self_refresh_exit_i),
    .last_data_out_o(last_data_out_i), .last_data_in_o(last_data_in_i), .activate_o(activate_i),
    .len_o(len), .done_o(done));
  // ****
  // Helpers
  // ****
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [31:0] fmask(int i);
    return i == 4 ? 32'h0000001F : 32'h0000000F;
  endfunction
  function automatic logic [31:0] radr(int i);
    return sdram_timing_pkg::SELF_REFRESH_EXIT_TIME_ADDR + 32'(4 * i);
  endfunction
  // Each event holds its own command for N+1 cycles
  function automatic logic [31:0] exp_len(int k);
    return fld[k] + 32'h1;
  endfunction
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] st);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    while (!(ta && tw)) begin
      @(negedge clk_sys_i);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge clk_sys_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    // Late ready keeps the answer waiting
    if (lag > 0) begin
      repeat (lag) @(posedge clk_sys_i);
      s_axi_bready <= 1'b1;
    end
    do @(negedge clk_sys_i); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge clk_sys_i);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do @(negedge clk_sys_i); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys_i);
    s_axi_arvalid <= 1'b0;
    if (lag > 0) begin
      repeat (lag) @(posedge clk_sys_i);
      s_axi_rready <= 1'b1;
    end
    do @(negedge clk_sys_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_sys_i);
    s_axi_rready <= 1'b0;
  endtask
  task automatic pace(input int k);
    @(posedge clk_sys_i);
    kind <= 3'(k);
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    do @(negedge clk_sys_i); while (done !== 1'b1);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      fld[i] = i == 4 ? 32'h0000001F : 32'h0000000F;
      rd(radr(i));
      chk_word("reset value", fld[i], d);
    end
    // Status shows the activate interval while it runs
    fork
      pace(4);
      begin
        repeat (8) @(posedge clk_sys_i);
        rd(sdram_timing_pkg::PACING_STATUS_ADDR);
        chk_word("pacing status", 32'h1 << sdram_timing_pkg::TMR_ACTIVATE, d);
        chk_resp("status answer", sdram_timing_pkg::RESP_OKAY, r);
      end
    join
    chk_word("reset hold length", exp_len(4), 32'(len));
    for (int it = 0; it < 7; it++) begin
      lag = (it & 1) * 3;
      for (int k = 0; k < 5; k++) begin
        pace(k);
        chk_word("hold length", exp_len(k), 32'(len));
      end
      // Reprogram only once every interval has run out, upper bits zero
      for (int i = 0; i < 5; i++) begin
        fld[i] = it == 0 ? 32'h0 : it == 1 ? fmask(i) : $random(seed) & fmask(i);
        wr(radr(i), fld[i], 4'hF);
        chk_resp("write answer", sdram_timing_pkg::RESP_OKAY, r);
        rd(radr(i));
        chk_word("read back", fld[i], d);
        chk_resp("read answer", sdram_timing_pkg::RESP_OKAY, r);
      end
    end
    wr(32'h80008050, 32'h00000005, 4'hF);
    chk_resp("unmapped write", sdram_timing_pkg::RESP_SLVERR, r);
    rd(32'h80008050);
    chk_resp("unmapped read", sdram_timing_pkg::RESP_SLVERR, r);
    wr(radr(4), ~fld[4] & 32'h0000001F, 4'hE);
    chk_resp("masked write answer", sdram_timing_pkg::RESP_OKAY, r);
    rd(radr(4));
    chk_word("masked write", fld[4], d);
    complete_run();
  end
endmodule
